/* sac_pkg.sv */
// Constants and types shared by the serial audio port configuration block.
// Assumes one 20 MHz clock and an 8-bit register port.
package sac_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int BCLK_HALF_NS = 200;
   // Least half period, rounded up, never below one cycle
   localparam int BCLK_HALF_RAW = (BCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BCLK_HALF_CYC = (BCLK_HALF_RAW < 1) ? 1 : BCLK_HALF_RAW;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_FORMAT = 8'h32;
   localparam logic [7:0] ADDR_FRAME = 8'h33;
   localparam logic [7:0] ADDR_SLOT_DIS = 8'h34;
   localparam logic [7:0] ADDR_STATUS = 8'h35;
   localparam logic [7:0] ADDR_MOD_EN = 8'h36;
   localparam logic [7:0] ADDR_PATTERN = 8'h37;
   localparam logic [7:0] REG_RST = 8'h00;
   // ==========================================================
   // Field positions
   localparam int FMT_LSB = 6;
   localparam int MODE_LSB = 4;
   localparam int FR_TRISTATE = 7;
   localparam int FR_SLOT_WIDTH = 6;
   localparam int FR_SHAPE = 5;
   localparam int FR_POL = 4;
   localparam int FR_ORDER = 3;
   localparam int FR_RATE = 2;
   localparam int FR_EDGE = 1;
   localparam int FR_ROLE = 0;
   localparam int MOD_INSERT = 4;
   localparam int MOD_CH_LSB = 2;
   localparam int MOD_MODE_LSB = 0;
   // ==========================================================
   // Sizes and counts
   localparam int SAMPLE_W = 24;
   localparam int FIFO_DEPTH = 4;
   localparam logic [4:0] WIDE_BITS = 5'h18;
   localparam logic [4:0] NARROW_BITS = 5'h10;
   localparam logic [5:0] BPC_LONG = 6'h20;
   localparam logic [5:0] BPC_SHORT = 6'h10;
   localparam logic [3:0] PAT_IDLE = 4'h8;
   // ==========================================================
   // Encodings
   typedef enum logic [1:0] {FMT_I2S = 2'h0, FMT_LJ = 2'h1, FMT_RJ24 = 2'h2, FMT_RJ16 = 2'h3} sac_fmt_t;
   typedef enum logic [1:0] {MODE_STEREO = 2'h0, MODE_TDM2 = 2'h1, MODE_TDM4 = 2'h2, MODE_TDM8 = 2'h3} sac_mode_t;
   typedef enum logic [1:0] {PCH_BOTH = 2'h0, PCH_LEFT = 2'h1, PCH_RIGHT = 2'h2, PCH_RSVD = 2'h3} sac_pch_t;
   typedef enum logic [1:0] {OUT_OFF = 2'h0, OUT_LEFT = 2'h1, OUT_RIGHT = 2'h2, OUT_STEREO = 2'h3} sac_omode_t;
endpackage

/* sac_top.sv */
// Serial audio port with TDM slot control and a density modulator output.
// Assumes a 20 MHz clock; link pins are asynchronous and synchronised here.
// What this block does
// R1 - Frame bit 6 picks 24-bit or 16-bit data per TDM slot
// R2 - Frame bit 5 picks 50% frame clock or one-bit-clock pulse
// R3 - Frame bit 4 sets frame clock polarity for both shapes
// R4 - Frame bit 3 sends MSB first when 0, LSB first when 1
// R5 - Frame bit 2 allots 32 or 16 bit clocks per channel
// R6 - Frame bit 1 picks falling or rising data change edge
// R7 - Frame bit 0 makes the port slave or clock master
// R8 - Each slot disable bit silences its TDM output slot
// R9 - Slot disables act only in TDM modes, never in stereo
// R10 - Modulator bit 4 enables pattern insertion into the stream
// R11 - Modulator bits 3:2 pick both, left or right for pattern
// R12 - Software leaves pattern channel alone while the stream runs
// R13 - Modulator bits 1:0 pick off, left, right or stereo output
// R14 - Pattern register holds the inserted byte, resets to zero
// R15 - Software leaves the pattern byte alone while it is sent
// R16 - Format field picks I2S delayed, left or right justified data
// R17 - Frame bit 7 tristates disabled slots instead of driving zero
// R18 - All configuration resets to zero: slave, 50%, MSB, 32, falling, off
//
// Decided for this implementation: the strobed register port.

// ==========================================================
// Sample FIFO
module sac_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 4
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_r, rd_r;
   logic [CW-1:0] count_r, count_nxt;
   logic push, pop;

   // Flags are registered so the ready seen outside comes from a flop
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_r];
   always_comb begin
      case ({push, pop})
         2'b10: count_nxt = count_r + CW'(1);
         2'b01: count_nxt = count_r - CW'(1);
         default: count_nxt = count_r;
      endcase
   end

   // Pointers and occupancy
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_r <= '0;
         rd_r <= '0;
         count_r <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + PW'(1);
         end
         if (pop) begin
            rd_r <= (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + PW'(1);
         end
         count_r <= count_nxt;
         in_ready <= count_nxt != CW'(DEPTH);
         out_valid <= count_nxt != '0;
      end
   end

   // Storage, no reset needed on data
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_r] <= in_data;
      end
   end
endmodule

// ==========================================================
// Top level
module sac_top (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [7:0] reg_rdata,
   input wire logic [sac_pkg::SAMPLE_W-1:0] smp_data,
   input wire logic smp_valid,
   output logic smp_ready,
   input wire logic bclk_i,
   output logic bclk_o,
   output logic bclk_oe,
   input wire logic fclk_i,
   output logic fclk_o,
   output logic fclk_oe,
   output logic sdout_o,
   output logic sdout_oe,
   output logic density_output_pin
);
   import sac_pkg::*;

   logic [7:0] fmt_r, frame_r, slot_dis_r, mod_r, pat_r;
   logic [7:0] div_r, pos_r, pos_n, last_pos, half;
   logic [8:0] frame_len;
   logic [5:0] bpc, off, rel;
   logic [4:0] width, bic_n, idx;
   logic [2:0] ch_n;
   logic [3:0] pat_cnt_r;
   logic [SAMPLE_W-1:0] word_r, word_nxt, left_r, right_r, fifo_data;
   logic b_s1, b_s2, b_s3, f_s1, f_s2, f_last_r, pend_r;
   logic tick, rise, fall, chg, smp, start_lvl, frame_start;
   logic tdm, master, slot_off, load, in_word, bit_n, fifo_valid, pattern_channel_select_r;
   logic [1:0] cand;
   sac_fmt_t fmt;
   sac_mode_t pmode;
   sac_pch_t chsel;
   sac_omode_t omode;

   // ==========================================================
   // Register port
   // R18 - zero after reset
   always_ff @(posedge clock) begin
      if (rst) begin
         fmt_r <= REG_RST;
         frame_r <= REG_RST;
         slot_dis_r <= REG_RST;
         mod_r <= REG_RST;
         pat_r <= REG_RST;
      end else if (reg_we) begin
         case (reg_addr)
            ADDR_FORMAT: fmt_r <= reg_wdata;
            ADDR_FRAME: frame_r <= reg_wdata;
            ADDR_SLOT_DIS: slot_dis_r <= reg_wdata;
            ADDR_MOD_EN: mod_r <= reg_wdata;
            // R14 - pattern byte store
            ADDR_PATTERN: pat_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clock) begin
      if (rst || !reg_re) begin
         reg_rdata <= 8'h00;
      end else begin
         case (reg_addr)
            ADDR_FORMAT: reg_rdata <= fmt_r;
            ADDR_FRAME: reg_rdata <= frame_r;
            ADDR_SLOT_DIS: reg_rdata <= slot_dis_r;
            ADDR_STATUS: reg_rdata <= {pos_r[7:5], pend_r, fclk_o, smp_ready, fifo_valid, master};
            ADDR_MOD_EN: reg_rdata <= mod_r;
            ADDR_PATTERN: reg_rdata <= pat_r;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Field decode
   assign fmt = sac_fmt_t'(fmt_r[FMT_LSB+:2]);
   assign pmode = sac_mode_t'(fmt_r[MODE_LSB+:2]);
   assign chsel = sac_pch_t'(mod_r[MOD_CH_LSB+:2]);
   assign omode = sac_omode_t'(mod_r[MOD_MODE_LSB+:2]);
   assign tdm = pmode != MODE_STEREO;
   // R7 - role select
   assign master = frame_r[FR_ROLE];
   // R5 - clocks per channel
   assign bpc = frame_r[FR_RATE] ? BPC_SHORT : BPC_LONG;
   // R1 - slot data width
   always_comb begin
      if (tdm) begin
         width = frame_r[FR_SLOT_WIDTH] ? NARROW_BITS : WIDE_BITS;
      end else begin
         width = (fmt == FMT_RJ16) ? NARROW_BITS : WIDE_BITS;
      end
   end
   // Frame length follows the channel count of the port mode
   always_comb begin
      unique case (pmode)
         MODE_TDM4: frame_len = {1'b0, bpc, 2'b00};
         MODE_TDM8: frame_len = {bpc, 3'b000};
         default: frame_len = {2'b00, bpc, 1'b0};
      endcase
   end
   assign last_pos = 8'(frame_len - 9'h001);
   assign half = frame_len[8:1];

   // ==========================================================
   // Bit clock: own divider as master, synchronised pin as slave
   assign tick = div_r == 8'(BCLK_HALF_CYC - 1);
   always_ff @(posedge clock) begin
      if (rst) begin
         div_r <= 8'h00;
         bclk_o <= 1'b0;
      end else begin
         div_r <= tick ? 8'h00 : div_r + 8'h01;
         bclk_o <= tick ? !bclk_o : bclk_o;
      end
   end

   // Two flops before any logic, a third only for edge finding
   always_ff @(posedge clock) begin
      if (rst) begin
         b_s1 <= 1'b0;
         b_s2 <= 1'b0;
         b_s3 <= 1'b0;
         f_s1 <= 1'b0;
         f_s2 <= 1'b0;
      end else begin
         b_s1 <= bclk_i;
         b_s2 <= b_s1;
         b_s3 <= b_s2;
         f_s1 <= fclk_i;
         f_s2 <= f_s1;
      end
   end

   assign rise = master ? (tick & !bclk_o) : (b_s2 & !b_s3);
   assign fall = master ? (tick & bclk_o) : (!b_s2 & b_s3);
   // R6 - data change edge
   assign chg = frame_r[FR_EDGE] ? rise : fall;
   assign smp = frame_r[FR_EDGE] ? fall : rise;
   // R3 - level that opens a frame
   assign start_lvl = frame_r[FR_SHAPE] ^ frame_r[FR_POL];

   // Slave framing: a change to the start level seen at a sample edge realigns
   always_ff @(posedge clock) begin
      if (rst) begin
         f_last_r <= 1'b0;
         pend_r <= 1'b0;
      end else if (smp) begin
         f_last_r <= f_s2;
         if (f_s2 != f_last_r && f_s2 == start_lvl) begin
            pend_r <= 1'b1;
         end
      end else if (chg) begin
         pend_r <= 1'b0;
      end
   end

   // ==========================================================
   // Frame position and slot data
   always_comb begin
      if (!master && pend_r) begin
         pos_n = 8'h01;
      end else if (pos_r >= last_pos) begin
         pos_n = 8'h00;
      end else begin
         pos_n = pos_r + 8'h01;
      end
   end
   assign frame_start = chg && pos_n == 8'h00;
   assign ch_n = frame_r[FR_RATE] ? pos_n[6:4] : pos_n[7:5];
   assign bic_n = frame_r[FR_RATE] ? {1'b0, pos_n[3:0]} : pos_n[4:0];
   // R8 R9 - per-slot disable, TDM only
   assign slot_off = tdm && slot_dis_r[ch_n];
   assign load = chg && bic_n == 5'h00;
   // Underrun sends silence rather than stalling the frame
   assign word_nxt = load ? ((slot_off || !fifo_valid) ? '0 : fifo_data) : word_r;

   // R16 - bit offset of the word inside the channel
   always_comb begin
      unique case (fmt)
         FMT_I2S: off = 6'h01;
         FMT_LJ: off = 6'h00;
         default: off = bpc - {1'b0, width};
      endcase
   end
   assign rel = {1'b0, bic_n} - off;
   assign in_word = ({1'b0, bic_n} >= off) && (rel < {1'b0, width});
   // R4 - bit order
   assign idx = frame_r[FR_ORDER] ? rel[4:0] : width - 5'h01 - rel[4:0];
   assign bit_n = in_word & word_nxt[idx];

   sac_fifo #(
      .WIDTH(SAMPLE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst(rst),
      .in_data(smp_data),
      .in_valid(smp_valid),
      .in_ready(smp_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(load && !slot_off)
   );

   // Shift out on each change edge
   always_ff @(posedge clock) begin
      if (rst) begin
         pos_r <= 8'h00;
         word_r <= '0;
         left_r <= '0;
         right_r <= '0;
         sdout_o <= 1'b0;
         sdout_oe <= 1'b0;
         fclk_o <= 1'b0;
      end else if (chg) begin
         pos_r <= pos_n;
         word_r <= word_nxt;
         sdout_o <= bit_n;
         // R17 - disabled slot tristate or driven low
         sdout_oe <= !(slot_off && frame_r[FR_TRISTATE]);
         // R2 R3 - frame clock shape and polarity
         fclk_o <= (frame_r[FR_SHAPE] ? (pos_n == 8'h00) : (pos_n >= half)) ^ frame_r[FR_POL];
         if (load && ch_n == 3'h0) begin
            left_r <= word_nxt;
         end
         if (load && ch_n == 3'h1) begin
            right_r <= word_nxt;
         end
      end
   end

   // R7 - clocks driven only as master
   always_ff @(posedge clock) begin
      if (rst) begin
         bclk_oe <= 1'b0;
         fclk_oe <= 1'b0;
      end else begin
         bclk_oe <= master;
         fclk_oe <= master;
      end
   end

   // ==========================================================
   // Density modulator, one first-order loop per channel
   for (genvar i = 0; i < 2; i++) begin : g_mod
      logic [24:0] acc_r;
      logic [SAMPLE_W-1:0] src;
      logic ins;
      // R13 - source channel per output mode
      assign src = (omode == OUT_RIGHT || (omode == OUT_STEREO && i == 1)) ? right_r : left_r;
      // R10 R11 - pattern insertion and channel choice; reserved code inserts nothing
      assign ins = mod_r[MOD_INSERT] && !pat_cnt_r[3] &&
         (chsel == PCH_BOTH || (chsel == PCH_LEFT && i == 0) || (chsel == PCH_RIGHT && i == 1));
      always_ff @(posedge clock) begin
         if (rst) begin
            acc_r <= '0;
         end else if (tick && pattern_channel_select_r == 1'(i)) begin
            acc_r <= {1'b0, acc_r[23:0]} + {1'b0, !src[23], src[22:0]};
         end
      end
      assign cand[i] = ins ? pat_r[3'h7 - pat_cnt_r[2:0]] : acc_r[24];
   end

   // Channels alternate per tick; the pattern restarts each frame
   always_ff @(posedge clock) begin
      if (rst) begin
         pattern_channel_select_r <= 1'b0;
         pat_cnt_r <= PAT_IDLE;
         density_output_pin <= 1'b0;
      end else begin
         if (tick) begin
            pattern_channel_select_r <= !pattern_channel_select_r;
         end
         if (frame_start) begin
            pat_cnt_r <= 4'h0;
         end else if (tick && pattern_channel_select_r && !pat_cnt_r[3]) begin
            pat_cnt_r <= pat_cnt_r + 4'h1;
         end
         // R13 - output off forces the pin low
         if (omode == OUT_OFF) begin
            density_output_pin <= 1'b0;
         end else if (tick) begin
            density_output_pin <= cand[pattern_channel_select_r];
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_wr_pat;
      reg_we && reg_addr == ADDR_PATTERN;
   endsequence
   sequence s_chg_first;
      chg && pos_n == 8'h00;
   endsequence
   property p_slot_width;
      tdm && frame_r[FR_SLOT_WIDTH] |-> width == 5'h10;
   endproperty
   a_slot_width: assert property (p_slot_width) else $error("slot width not 16"); // R1
   property p_pulse;
      (master && frame_r[FR_SHAPE]) and s_chg_first |=> fclk_o == !$past(frame_r[FR_POL]);
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse missing at frame start"); // R2
   property p_half;
      (master && !frame_r[FR_SHAPE]) and s_chg_first |=> fclk_o == $past(frame_r[FR_POL]);
   endproperty
   a_half: assert property (p_half) else $error("half frame level wrong"); // R3
   property p_bpc;
      frame_r[FR_RATE] |-> last_pos[3:0] == 4'hf && bpc == 6'h10;
   endproperty
   a_bpc: assert property (p_bpc) else $error("clocks per channel wrong"); // R5
   // Settings of the launching edge, so a frame write on that edge is not blamed
   property p_edge;
      $past(master) && $changed(sdout_o) |-> bclk_o == $past(frame_r[FR_EDGE]);
   endproperty
   a_edge: assert property (p_edge) else $error("data changed on wrong edge"); // R6
   property p_role;
      !master ##1 !master |-> !bclk_oe && !fclk_oe;
   endproperty
   a_role: assert property (p_role) else $error("slave drives clocks"); // R7
   property p_slot_off;
      chg && tdm && slot_dis_r[ch_n] && frame_r[FR_TRISTATE] |=> !sdout_oe;
   endproperty
   a_slot_off: assert property (p_slot_off) else $error("disabled slot driven"); // R8
   property p_stereo;
      chg && !tdm |=> sdout_oe;
   endproperty
   a_stereo: assert property (p_stereo) else $error("stereo slot silenced"); // R9
   property p_pdm_off;
      omode == OUT_OFF |=> !density_output_pin;
   endproperty
   a_pdm_off: assert property (p_pdm_off) else $error("modulator pin active while off"); // R13
   property p_pat_wr;
      s_wr_pat |=> pat_r == $past(reg_wdata);
   endproperty
   a_pat_wr: assert property (p_pat_wr) else $error("pattern byte not stored"); // R14
   property p_reset;
      $past(rst) |-> frame_r == 8'h00 && mod_r == 8'h00 && pat_r == 8'h00;
   endproperty
   a_reset: assert property (p_reset) else $error("config not zero after reset"); // R18
endmodule

/* sac_host_model.sv */
// Host audio processor driving the serial port clocks while the block is slave.
// Assumes left justified stereo, 50% frame clock, 32 bit clocks per channel.
// ==========================================================
// Host model
module sac_host_model (
   input wire logic run,
   input wire logic sdata,
   output logic bclk,
   output logic fclk,
   output logic [23:0] left_word,
   output int frames
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [23:0] shift;
   // Idle high so the first edge of a frame is a falling one
   initial begin
      bclk = 1'b1;
      fclk = 1'b1;
      left_word = '0;
      frames = 0;
      shift = '0;
   end
   // One frame per pass; clocks stand still between frames when run is low
   // host makes clocks
   always begin
      wait (run === 1'b1);
      for (int ch = 0; ch < 2; ch++) begin
         for (int b = 0; b < 32; b++) begin
            #200 bclk = 1'b0;
            if (b == 0) fclk = (ch == 1);
            #200 bclk = 1'b1;
            if (ch == 0 && b < 24) shift = {shift[22:0], sdata};
         end
         if (ch == 0) begin
            left_word = shift;
            frames++;
         end
      end
   end
endmodule

/* testbench.sv */
// Self-checking bench for the serial audio port configuration block.
// Assumes the host model file is compiled first; register port has no waits.
// ==========================================================
// Bench top
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import sac_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = '0;
   logic [7:0] reg_wdata = '0;
   logic reg_we = 1'b0;
   logic reg_re = 1'b0;
   logic [7:0] reg_rdata;
   logic [23:0] smp_data = '0;
   logic smp_valid = 1'b0;
   logic smp_ready, bclk_o, bclk_oe, fclk_o, fclk_oe, sdout_o, sdout_oe, density_output_pin;
   logic host_run = 1'b0;
   logic host_bclk, host_fclk;
   logic [23:0] host_word, w;
   int host_frames, c, n;
   int failures = 0;
   int total_checks = 0;
   // Pin levels from both parties; undriven data shows the inverse of its last value
   wire bclk_w = bclk_oe ? bclk_o : host_bclk;
   wire fclk_w = fclk_oe ? fclk_o : host_fclk;
   wire sd_w = sdout_oe ? sdout_o : ~sdout_o;
   localparam logic [23:0] WORD = 24'hc30a51;
   logic [7:0] ra [5] = '{8'h32, 8'h33, 8'h34, 8'h37, 8'h36};
   logic [7:0] rv [5] = '{8'hf7, 8'hfe, 8'ha5, 8'h3c, 8'h1f};
   logic [7:0] mc [4] = '{8'h01, 8'h05, 8'h21, 8'h31};
   logic ml [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
   int me [4] = '{256, 128, 8, 8};

   always #25 clock = ~clock;

   sac_top sac_top_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .smp_data(smp_data),
      .smp_valid(smp_valid), .smp_ready(smp_ready), .bclk_i(bclk_w), .bclk_o(bclk_o),
      .bclk_oe(bclk_oe), .fclk_i(fclk_w), .fclk_o(fclk_o), .fclk_oe(fclk_oe), .sdout_o(sdout_o),
      .sdout_oe(sdout_oe), .density_output_pin(density_output_pin));

   sac_host_model sac_host_model_inst (.run(host_run), .sdata(sd_w), .bclk(host_bclk),
      .fclk(host_fclk), .left_word(host_word), .frames(host_frames));

   // ==========================================================
   // Compare tasks
   task automatic miss(input logic [31:0] got, input logic [31:0] exp);
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
   endtask
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) miss(got, exp);
   endtask
   task automatic check24(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp) miss(got, exp);
   endtask
   task automatic check1(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) miss(got, exp);
   endtask
   task automatic check_count(input int got, input int exp, input logic more);
      total_checks++;
      if (more ? (got <= exp) : (got != exp)) miss(got, exp);
   endtask

   // ==========================================================
   // Access tasks
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clock);
      reg_we <= 1'b0;
   endtask
   task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clock);
      reg_re <= 1'b0;
      @(negedge clock);
      check8(reg_rdata, exp);
   endtask
   // Valid drops at the taking edge itself, so a word is never taken twice
   task automatic push4();
      int k;
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         smp_data <= WORD;
         smp_valid <= 1'b1;
         k = 0;
         @(negedge clock);
         while (smp_ready !== 1'b1 && k < 20000) begin
            @(negedge clock);
            k++;
         end
         @(posedge clock);
         smp_valid <= 1'b0;
      end
   endtask
   // Waits for a change of sig to level lv, seen at falling clock edges
   task automatic wait_to(input logic lv, input logic use_bclk);
      int k;
      logic p;
      k = 0;
      p = use_bclk ? bclk_o : fclk_o;
      @(negedge clock);
      while ((p === lv || (use_bclk ? bclk_o : fclk_o) !== lv) && k < 5000) begin
         p = use_bclk ? bclk_o : fclk_o;
         @(negedge clock);
         k++;
      end
      if (k >= 5000) miss(k, 5000);
   endtask
   task automatic capture(input logic rise_chg, output logic [23:0] v);
      wait_to(1'b0, 1'b0);
      for (int i = 0; i < 24; i++) begin
         wait_to(rise_chg ? 1'b0 : 1'b1, 1'b1);
         v = {v[22:0], sdout_o};
      end
   endtask
   task automatic measure(input logic lv, output int clks);
      wait_to(lv, 1'b0);
      clks = 0;
      while (fclk_o === lv && clks < 5000) begin
         @(negedge clock);
         clks++;
      end
   endtask
   task automatic toggles(output int t);
      logic p;
      t = 0;
      for (int i = 0; i < 400; i++) begin
         p = density_output_pin;
         @(negedge clock);
         if (density_output_pin !== p) t++;
      end
   endtask
   function automatic logic [23:0] rev24(input logic [23:0] v);
      for (int i = 0; i < 24; i++) rev24[i] = v[23 - i];
   endfunction

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Cuts a hang short well past the expected run length
   initial begin
      #(50 * 90000);
      failures++;
      tally_and_finish();
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) read_check(ra[i], 8'h00);
      reg_write(8'h40, 8'hff);
      read_check(8'h40, 8'h00);
      // Pattern byte goes in before the modulator runs, cleared after it stops
      for (int i = 0; i < 5; i++) reg_write(ra[i], rv[i]);
      for (int i = 0; i < 5; i++) read_check(ra[i], rv[i]);
      for (int i = 4; i >= 0; i--) reg_write(ra[i], 8'h00);
      // Slave, host stopped: buffer fills until it refuses
      reg_write(ADDR_FORMAT, 8'h40);
      push4();
      repeat (2) @(negedge clock);
      check1(smp_ready, 1'b0);
      check1(bclk_oe, 1'b0);
      check1(fclk_oe, 1'b0);
      host_run <= 1'b1;
      n = 0;
      while (host_frames < 2 && n < 40000) begin
         @(negedge clock);
         n++;
      end
      host_run <= 1'b0;
      check24(host_word, WORD);
      repeat (600) @(negedge clock);
      check1(smp_ready, 1'b1);
      // Master: bit order and change edge seen on the pins
      reg_write(ADDR_FRAME, 8'h01);
      push4();
      capture(1'b0, w);
      check24(w, WORD);
      check1(bclk_oe, 1'b1);
      reg_write(ADDR_FRAME, 8'h09);
      push4();
      capture(1'b0, w);
      check24(w, rev24(WORD));
      reg_write(ADDR_FRAME, 8'h0b);
      push4();
      capture(1'b1, w);
      check24(w, rev24(WORD));
      // Frame clock half length, pulse width and polarity; first reading discarded
      for (int i = 0; i < 4; i++) begin
         reg_write(ADDR_FRAME, mc[i]);
         measure(ml[i], c);
         measure(ml[i], c);
         check_count(c, me[i], 1'b0);
      end
      // TDM2 with slot 0 disabled and tristated, then the same in stereo
      reg_write(ADDR_FORMAT, 8'h50);
      reg_write(ADDR_FRAME, 8'h81);
      reg_write(ADDR_SLOT_DIS, 8'h01);
      // First fall may come from the shape change mid-frame; the second is a frame start
      wait_to(1'b0, 1'b0);
      wait_to(1'b0, 1'b0);
      repeat (8) @(negedge clock);
      check1(sdout_oe, 1'b0);
      repeat (256) @(negedge clock);
      check1(sdout_oe, 1'b1);
      reg_write(ADDR_FORMAT, 8'h40);
      wait_to(1'b0, 1'b0);
      wait_to(1'b0, 1'b0);
      repeat (8) @(negedge clock);
      check1(sdout_oe, 1'b1);
      // Modulator pin idle when off, active in each other mode
      toggles(c);
      check_count(c, 0, 1'b0);
      check1(density_output_pin, 1'b0);
      for (int m = 1; m < 4; m++) begin
         reg_write(ADDR_MOD_EN, m[7:0]);
         toggles(c);
         check_count(c, 0, 1'b1);
      end
      // Pattern set while the modulator is stopped, then sent at the next frame start
      reg_write(ADDR_MOD_EN, 8'h00);
      reg_write(ADDR_PATTERN, 8'hff);
      reg_write(ADDR_MOD_EN, 8'h11);
      wait_to(1'b0, 1'b0);
      for (int i = 0; i < 8; i++) begin
         repeat (4) @(negedge clock);
         check1(density_output_pin, 1'b1);
      end
      tally_and_finish();
   end
endmodule
